// file: violation_access_pkg.sv
// Constants for the violation counter access block.
// Assumes a 100 MHz clock and a 32-bit byte-addressed register bus.
package violation_access_pkg;
  localparam int NUM_CHANNELS = 14;
  localparam int COUNT_WIDTH  = 16;
  localparam int ADDR_WIDTH   = 10;
  localparam int DATA_WIDTH   = 32;
  localparam logic [COUNT_WIDTH-1:0] COUNT_FULL = 16'hFFFF;
  localparam logic [COUNT_WIDTH-1:0] COUNT_ZERO = 16'h0000;

  // Register indices; byte address is four times the index
  localparam logic [7:0] IDX_ACCESS_CTL  = 8'hE5;
  localparam logic [7:0] IDX_COUNTER_CTL = 8'hE6;
  localparam logic [7:0] IDX_COUNT_BYTE  = 8'hE8;
  localparam logic [7:0] IDX_IRQ_STATUS  = 8'hF0;
  localparam logic [7:0] IDX_IRQ_MASK    = 8'hF1;
  localparam logic [7:0] IDX_MONITOR     = 8'hF2;

  // Access control fields
  localparam int BIT_MONITOR_SOURCE = 7;
  localparam int BIT_READBACK_EN    = 6;
  localparam int SEL_LSB            = 0;
  localparam int SEL_WIDTH          = 4;
  localparam logic [7:0] ACCESS_CTL_MASK  = 8'hCF;
  localparam logic [7:0] ACCESS_CTL_RESET = 8'h00;
  localparam logic [SEL_WIDTH-1:0] SEL_NONE = 4'h0;
  localparam logic [SEL_WIDTH-1:0] SEL_LAST = 4'hE;
  localparam logic [SEL_WIDTH-1:0] SEL_STEP = 4'h1;

  // Counter control fields
  localparam int BIT_CLEAR_ALL  = 4;
  localparam int BIT_LATCH_ALL  = 3;
  localparam int BIT_BYTE_SEL   = 2;
  localparam int BIT_LATCH_ONE  = 1;
  localparam int BIT_CLEAR_ONE  = 0;
  localparam logic [7:0] COUNTER_CTL_MASK  = 8'h1F;
  localparam logic [7:0] COUNTER_CTL_RESET = 8'h00;
  localparam logic [NUM_CHANNELS-1:0] CHAN_ZERO = 14'h0000;

  // Clear hold time, least time so rounded up
  localparam int CLOCK_PERIOD_NS = 10;
  localparam int CLEAR_TIME_NS   = 1000;
  localparam int CLEAR_CYCLES_I  = (CLEAR_TIME_NS + CLOCK_PERIOD_NS - 1) / CLOCK_PERIOD_NS;
  localparam logic [7:0] CLEAR_CYCLES = 8'(CLEAR_CYCLES_I);
  localparam logic [7:0] HOLD_ZERO    = 8'h00;
  localparam logic [7:0] HOLD_STEP    = 8'h01;
endpackage

// file: violation_counter.sv
// One saturating 16-bit violation counter with synchronous clear.
// Assumes increment and clear come from logic on the same clock.
`timescale 1ns/100ps
`default_nettype none
module violation_counter (
  input  wire logic                                        clock_in,
  input  wire logic                                        resetn_in,
  input  wire logic                                        increment_in,
  input  wire logic                                        clear_in,
  output logic [violation_access_pkg::COUNT_WIDTH-1:0]     count_out,
  output logic                                             saturated_out
);
  import violation_access_pkg::*;

  logic [COUNT_WIDTH-1:0] count_reg;
  logic [COUNT_WIDTH-1:0] count_next;
  wire                    full_w = (count_reg == COUNT_FULL);

  // Clear beats increment; a full counter never wraps
  assign count_next = clear_in ? COUNT_ZERO :
                      (increment_in && !full_w) ? count_reg + 16'h0001 : count_reg;

  always_ff @(posedge clock_in or negedge resetn_in) begin
    if (!resetn_in) begin
      count_reg <= COUNT_ZERO;
    end else begin
      count_reg <= count_next;
    end
  end

  assign count_out     = count_reg;
  assign saturated_out = full_w;

  a_saturate_hold: assert property (@(posedge clock_in) disable iff (!resetn_in)
    full_w && !clear_in |=> count_reg == COUNT_FULL)
    else $error("Full counter moved without a clear");
  a_clear_zero: assert property (@(posedge clock_in) disable iff (!resetn_in)
    clear_in |=> count_reg == COUNT_ZERO)
    else $error("Counter not zero after clear");
endmodule
`default_nettype wire

// file: line_code_violation_counter_access.sv
// Register bank for reading the 14 per-channel violation counters.
// Assumes violation pulses come from same-clock line logic and an
// Avalon-MM master that holds each request until waitrequest is low.
`timescale 1ns/100ps
`default_nettype none
module line_code_violation_counter_access (
  input  wire logic                                              clock_in,
  input  wire logic                                              resetn_in,
  input  wire logic [violation_access_pkg::ADDR_WIDTH-1:0]       address_in,
  input  wire logic                                              read_in,
  input  wire logic                                              write_in,
  input  wire logic [3:0]                                        byteenable_in,
  input  wire logic [violation_access_pkg::DATA_WIDTH-1:0]       writedata_in,
  output logic [violation_access_pkg::DATA_WIDTH-1:0]            readdata_out,
  output logic                                                   waitrequest_out,
  input  wire logic [violation_access_pkg::NUM_CHANNELS-1:0]     violation_in,
  output logic [violation_access_pkg::NUM_CHANNELS-1:0]          monitor_status_out,
  output logic                                                   irq_out
);
  import violation_access_pkg::*;

  // Bus and register state
  logic                    wait_reg;
  logic [DATA_WIDTH-1:0]   rdata_reg;
  logic [DATA_WIDTH-1:0]   rdata_next;
  logic [7:0]              access_ctl_reg;
  logic [7:0]              counter_ctl_reg;
  logic [NUM_CHANNELS-1:0] status_reg;
  logic [NUM_CHANNELS-1:0] status_next;
  logic [NUM_CHANNELS-1:0] mask_reg;
  logic [NUM_CHANNELS-1:0] monitor_reg;
  logic [NUM_CHANNELS-1:0] sat_prev_reg;
  logic                    irq_reg;
  logic [7:0]              hold_time_reg;
  logic [7:0]              hold_time_next;
  logic [COUNT_WIDTH-1:0]  hold_reg [NUM_CHANNELS];
  logic [COUNT_WIDTH-1:0]  count_w  [NUM_CHANNELS];
  logic [NUM_CHANNELS-1:0] sat_w;
  logic [NUM_CHANNELS-1:0] sel_hit;
  logic [NUM_CHANNELS-1:0] clear_w;

  // Address decode; one access completes in the cycle waitrequest is low
  wire [7:0] reg_index  = address_in[ADDR_WIDTH-1:2];
  wire       done       = (read_in || write_in) && !wait_reg;
  wire       wr_done    = write_in && !wait_reg;
  wire       lane0      = byteenable_in[0];
  wire       lane1      = byteenable_in[1];
  wire       hit_access = (reg_index == IDX_ACCESS_CTL);
  wire       hit_cctl   = (reg_index == IDX_COUNTER_CTL);
  wire       hit_byte   = (reg_index == IDX_COUNT_BYTE);
  wire       hit_status = (reg_index == IDX_IRQ_STATUS);
  wire       hit_mask   = (reg_index == IDX_IRQ_MASK);
  wire       hit_mon    = (reg_index == IDX_MONITOR);
  wire       wr_access  = wr_done && hit_access && lane0;
  wire       wr_cctl    = wr_done && hit_cctl && lane0;
  wire       wr_status  = wr_done && hit_status;
  wire       wr_mask    = wr_done && hit_mask;

  // Lane-qualified write data for the 14-bit registers
  wire [15:0] wr_lanes = {lane1 ? writedata_in[15:8] : 8'h00,
                          lane0 ? writedata_in[7:0]  : 8'h00};
  wire [NUM_CHANNELS-1:0] wr_bits = wr_lanes[NUM_CHANNELS-1:0];
  wire [NUM_CHANNELS-1:0] mask_next =
    wr_mask ? ((mask_reg & ~{{6{lane1}}, {8{lane0}}}) | wr_bits) : mask_reg;

  // Channel select: zero or codes above fourteen address nothing
  wire [SEL_WIDTH-1:0] sel_code  = access_ctl_reg[SEL_LSB +: SEL_WIDTH];
  wire                 sel_valid = (sel_code != SEL_NONE) && (sel_code <= SEL_LAST);
  wire [SEL_WIDTH-1:0] sel_index = sel_valid ? sel_code - SEL_STEP : SEL_NONE;

  // Latch requests act on the 0-to-1 write of their bit only
  wire latch_one = wr_cctl && writedata_in[BIT_LATCH_ONE] && !counter_ctl_reg[BIT_LATCH_ONE];
  wire latch_all = wr_cctl && writedata_in[BIT_LATCH_ALL] && !counter_ctl_reg[BIT_LATCH_ALL];

  // Clear waits out the hold time so a glitchy write cannot wipe counts
  wire holding    = counter_ctl_reg[BIT_CLEAR_ALL] || counter_ctl_reg[BIT_CLEAR_ONE];
  wire clear_fire = holding && (hold_time_reg == CLEAR_CYCLES);
  assign hold_time_next = !holding ? HOLD_ZERO :
                          clear_fire ? hold_time_reg : hold_time_reg + HOLD_STEP;

  // Byte readback: zero unless enabled and a channel is selected
  wire [COUNT_WIDTH-1:0] held_sel  = hold_reg[sel_index];
  wire                   rb_on     = access_ctl_reg[BIT_READBACK_EN] && sel_valid;
  wire [7:0]             byte_pick = counter_ctl_reg[BIT_BYTE_SEL] ?
                                     held_sel[15:8] : held_sel[7:0];
  wire [7:0]             byte_rd   = rb_on ? byte_pick : 8'h00;

  // Read mux; unmapped addresses read zero
  assign rdata_next =
    hit_access ? {24'h000000, access_ctl_reg} :
    hit_cctl   ? {24'h000000, counter_ctl_reg} :
    hit_byte   ? {24'h000000, byte_rd} :
    hit_status ? {18'h00000, status_reg} :
    hit_mask   ? {18'h00000, mask_reg} :
    hit_mon    ? {18'h00000, monitor_reg} : 32'h00000000;

  // Set beats a same-cycle write-one-to-clear
  wire [NUM_CHANNELS-1:0] overflow_rise = sat_w & ~sat_prev_reg;
  assign status_next = (status_reg & ~(wr_status ? wr_bits : CHAN_ZERO)) | overflow_rise;

  // Per-channel counters, select decode and clear routing
  genvar gi;
  generate
    for (gi = 0; gi < NUM_CHANNELS; gi++) begin : g_chan
      assign sel_hit[gi] = sel_valid && (sel_index == SEL_WIDTH'(gi));
      assign clear_w[gi] = clear_fire && (counter_ctl_reg[BIT_CLEAR_ALL] ||
                           (counter_ctl_reg[BIT_CLEAR_ONE] && sel_hit[gi]));

      violation_counter u_counter (
        .clock_in      (clock_in),
        .resetn_in     (resetn_in),
        .increment_in  (violation_in[gi]),
        .clear_in      (clear_w[gi]),
        .count_out     (count_w[gi]),
        .saturated_out (sat_w[gi])
      );

      // Holding register gives software a stable snapshot
      always_ff @(posedge clock_in or negedge resetn_in) begin
        if (!resetn_in) begin
          hold_reg[gi] <= COUNT_ZERO;
        end else if (latch_all || (latch_one && sel_hit[gi])) begin
          hold_reg[gi] <= count_w[gi];
        end
      end
    end
  endgenerate

  // Bus handshake: waitrequest drops for exactly one cycle per request
  always_ff @(posedge clock_in or negedge resetn_in) begin
    if (!resetn_in) begin
      wait_reg  <= 1'b1;
      rdata_reg <= 32'h00000000;
    end else begin
      wait_reg  <= (read_in || write_in) ? !wait_reg : 1'b1;
      rdata_reg <= (read_in && wait_reg) ? rdata_next : rdata_reg;
    end
  end

  // Control registers; select starts at none
  always_ff @(posedge clock_in or negedge resetn_in) begin
    if (!resetn_in) begin
      access_ctl_reg  <= ACCESS_CTL_RESET;
      counter_ctl_reg <= COUNTER_CTL_RESET;
    end else begin
      if (wr_access) begin
        access_ctl_reg <= writedata_in[7:0] & ACCESS_CTL_MASK;
      end
      if (wr_cctl) begin
        counter_ctl_reg <= writedata_in[7:0] & COUNTER_CTL_MASK;
      end
    end
  end

  // Status, mask, monitor and interrupt
  always_ff @(posedge clock_in or negedge resetn_in) begin
    if (!resetn_in) begin
      status_reg    <= CHAN_ZERO;
      mask_reg      <= CHAN_ZERO;
      monitor_reg   <= CHAN_ZERO;
      sat_prev_reg  <= CHAN_ZERO;
      irq_reg       <= 1'b0;
      hold_time_reg <= HOLD_ZERO;
    end else begin
      status_reg    <= status_next;
      mask_reg      <= mask_next;
      monitor_reg   <= access_ctl_reg[BIT_MONITOR_SOURCE] ? sat_w : violation_in;
      sat_prev_reg  <= sat_w;
      irq_reg       <= |(status_next & mask_next);
      hold_time_reg <= hold_time_next;
    end
  end

  assign readdata_out       = rdata_reg;
  assign waitrequest_out    = wait_reg;
  assign monitor_status_out = monitor_reg;
  assign irq_out            = irq_reg;

  // Checks on the block's own behaviour
  default clocking cb @(posedge clock_in); endclocking
  default disable iff (!resetn_in);

  // Watched on the last channel, the one the bench drives to full scale
  a_overflow_sticky: assert property (
    $rose(sat_w[NUM_CHANNELS-1]) |=> status_reg[NUM_CHANNELS-1] &&
    (irq_out || !mask_reg[NUM_CHANNELS-1]))
    else $error("Overflow did not set status");
  a_monitor_violation: assert property (
    !access_ctl_reg[BIT_MONITOR_SOURCE] |=> monitor_status_out == $past(violation_in))
    else $error("Monitor does not follow violations");
  a_monitor_overflow: assert property (
    access_ctl_reg[BIT_MONITOR_SOURCE] |=> monitor_status_out == $past(sat_w))
    else $error("Monitor does not follow overflow");
  a_readback_gate: assert property (
    read_in && wait_reg && hit_byte && !access_ctl_reg[BIT_READBACK_EN]
    |=> readdata_out == 32'h00000000)
    else $error("Counter byte readable while disabled");
  a_none_selected: assert property (
    sel_code == SEL_NONE |-> sel_hit == CHAN_ZERO)
    else $error("Select zero addressed a channel");
  a_select_first: assert property (
    sel_code == SEL_STEP |-> sel_hit == 14'h0001)
    else $error("Code one did not pick channel 0");
  a_latch_copy: assert property (
    latch_one && sel_hit[0] |=> hold_reg[0] == $past(count_w[0]))
    else $error("Latch did not copy counter");
  a_byte_high: assert property (
    read_in && wait_reg && hit_byte && rb_on && counter_ctl_reg[BIT_BYTE_SEL]
    |=> readdata_out[7:0] == $past(held_sel[15:8]))
    else $error("High byte not returned");
  a_clear_wait: assert property (
    $rose(holding) |-> !clear_fire ##1 !clear_fire[*8])
    else $error("Clear fired before hold time");
  a_clear_scope: assert property (
    clear_fire && !counter_ctl_reg[BIT_CLEAR_ALL] |-> clear_w == sel_hit)
    else $error("Single clear hit wrong channel");
  a_wait_release: assert property (
    done |=> waitrequest_out)
    else $error("Waitrequest low twice for one request");

  // Bus timing: one wait state, then read data stands until the next read
  a_answer_next: assert property (
    (read_in || write_in) && wait_reg |=> !waitrequest_out)
    else $error("Request not answered after one wait state");
  a_idle_waits: assert property (
    !read_in && !write_in |=> waitrequest_out)
    else $error("Waitrequest low with no request");
  a_rdata_stands: assert property (
    !(read_in && wait_reg) |=> $stable(readdata_out))
    else $error("Read data changed outside a read");
  a_byte_upper: assert property (
    read_in && wait_reg && hit_byte |=> readdata_out[31:8] == 24'h000000)
    else $error("Counter byte read has upper bits set");

  // Control writes: reserved bits stay zero, lane 0 gates the byte registers
  a_access_reserved: assert property (
    (access_ctl_reg & ~ACCESS_CTL_MASK) == 8'h00)
    else $error("Reserved access control bit set");
  a_cctl_reserved: assert property (
    (counter_ctl_reg & ~COUNTER_CTL_MASK) == 8'h00)
    else $error("Reserved counter control bit set");
  a_access_write: assert property (
    wr_access |=> access_ctl_reg == ($past(writedata_in[7:0]) & ACCESS_CTL_MASK))
    else $error("Access control write lost");
  a_lane_guard: assert property (
    write_in && !wait_reg && hit_access && !lane0 |=> $stable(access_ctl_reg))
    else $error("Access control written without lane 0");
  a_mask_lane: assert property (
    wr_mask && !lane1 |=> mask_reg[13:8] == $past(mask_reg[13:8]))
    else $error("Mask high lane written without its enable");

  // Select decode: the last code and the unused code
  a_select_last: assert property (
    sel_code == SEL_LAST |-> sel_hit == 14'h2000)
    else $error("Code fourteen did not pick channel 13");
  a_select_over: assert property (
    sel_code > SEL_LAST |-> sel_hit == CHAN_ZERO)
    else $error("Unused select code addressed a channel");
  a_select_single: assert property (
    $onehot0(sel_hit))
    else $error("More than one channel addressed");

  // Holding registers change only on a latch
  a_latch_all_copy: assert property (
    latch_all |=> hold_reg[NUM_CHANNELS-1] == $past(count_w[NUM_CHANNELS-1]))
    else $error("Latch all did not copy counter");
  a_hold_steady: assert property (
    !latch_all && !(latch_one && sel_hit[NUM_CHANNELS-1])
    |=> $stable(hold_reg[NUM_CHANNELS-1]))
    else $error("Held count moved without a latch");
  a_byte_low: assert property (
    read_in && wait_reg && hit_byte && rb_on && !counter_ctl_reg[BIT_BYTE_SEL]
    |=> readdata_out[7:0] == $past(held_sel[7:0]))
    else $error("Low byte not returned");
  a_overflow_flag: assert property (
    sat_w[NUM_CHANNELS-1] == (count_w[NUM_CHANNELS-1] == COUNT_FULL))
    else $error("Saturation flag disagrees with count");

  // Clear timer counts one per cycle and restarts when the bit drops
  a_hold_count: assert property (
    holding && !clear_fire
    |=> !holding || hold_time_reg == $past(hold_time_reg) + HOLD_STEP)
    else $error("Clear hold timer skipped a cycle");
  a_hold_idle: assert property (
    !holding |=> hold_time_reg == HOLD_ZERO)
    else $error("Clear hold timer not restarted");

  // Status is write-one-to-clear, a new overflow wins, irq follows the level
  a_status_w1c: assert property (
    wr_status |=> (status_reg & $past(wr_bits & ~overflow_rise)) == CHAN_ZERO)
    else $error("Status bit survived write one to clear");
  a_status_set: assert property (
    (|overflow_rise) |=> (status_reg & $past(overflow_rise)) == $past(overflow_rise))
    else $error("Overflow lost against a clear");
  a_irq_level: assert property (
    irq_out == |(status_reg & mask_reg))
    else $error("Interrupt does not match masked status");

  c_readback: cover property (read_in && !wait_reg && hit_byte && rb_on);
  c_saturate: cover property ($rose(sat_w[NUM_CHANNELS-1]));
  c_clear:    cover property (clear_fire);
  c_irq:      cover property ($rose(irq_out));
  c_latch:    cover property (latch_all || latch_one);
endmodule
`default_nettype wire

// file: line_code_violation_counter_access_tb.sv
// Self-checking bench for the violation counter access register bank.
// Assumes the package constants and a one-wait-state Avalon-MM slave.
`timescale 1ns/100ps
`default_nettype none
module line_code_violation_counter_access_tb;
  import violation_access_pkg::*;

  logic                    clock_in     = 1'b0;
  logic                    resetn_in    = 1'b0;
  logic [ADDR_WIDTH-1:0]   address_in   = '0;
  logic                    read_in      = 1'b0;
  logic                    write_in     = 1'b0;
  logic [3:0]              byteenable_in = 4'hF;
  logic [DATA_WIDTH-1:0]   writedata_in = '0;
  logic [DATA_WIDTH-1:0]   readdata_out;
  logic                    waitrequest_out;
  logic [NUM_CHANNELS-1:0] violation_in = CHAN_ZERO;
  logic [NUM_CHANNELS-1:0] monitor_status_out;
  logic                    irq_out;
  int                      error_cnt   = 0;
  int                      check_count = 0;

  line_code_violation_counter_access DUT (
    .clock_in(clock_in), .resetn_in(resetn_in), .address_in(address_in),
    .read_in(read_in), .write_in(write_in), .byteenable_in(byteenable_in),
    .writedata_in(writedata_in), .readdata_out(readdata_out),
    .waitrequest_out(waitrequest_out), .violation_in(violation_in),
    .monitor_status_out(monitor_status_out), .irq_out(irq_out));

  // Free-running 100 MHz clock
  always #5 clock_in = ~clock_in;

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      error_cnt++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // One bus transfer; request held until the edge that sees waitrequest low
  task automatic xfer(input logic is_wr, input logic [7:0] idx, input logic [31:0] wd,
                      output logic [31:0] rd_val);
    @(posedge clock_in);
    address_in   <= {idx, 2'b00};
    writedata_in <= wd;
    write_in     <= is_wr;
    read_in      <= ~is_wr;
    do @(posedge clock_in); while (waitrequest_out !== 1'b0);
    rd_val = readdata_out;
    write_in <= 1'b0;
    read_in  <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] idx, input logic [31:0] wd);
    logic [31:0] dummy;
    xfer(1'b1, idx, wd, dummy);
  endtask

  task automatic rd_chk(input logic [7:0] idx, input logic [31:0] exp);
    logic [31:0] got;
    xfer(1'b0, idx, 32'h0, got);
    check(got, exp);
  endtask

  task automatic conclude;
    $display("Checks %0d, mismatches %0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  // Watchdog: the run needs about 66k cycles, so 90k cycles means a hang
  initial begin
    #900000;
    error_cnt++;
    conclude();
  end

  // Main sequence
  initial begin
    int k;
    repeat (2) @(posedge clock_in);
    resetn_in <= 1'b1;
    rd_chk(IDX_ACCESS_CTL, 32'h0);
    rd_chk(IDX_COUNTER_CTL, 32'h0);
    rd_chk(IDX_COUNT_BYTE, 32'h0);
    wr(IDX_ACCESS_CTL, 32'hFF);
    rd_chk(IDX_ACCESS_CTL, 32'hCF);
    // Without lane 0 the byte-wide control register keeps its value
    byteenable_in <= 4'hE;
    wr(IDX_ACCESS_CTL, 32'h00);
    byteenable_in <= 4'hF;
    rd_chk(IDX_ACCESS_CTL, 32'hCF);
    rd_chk(8'h10, 32'h0);
    // Channel c sees c+1 violations, so each count names its channel
    for (k = 0; k < NUM_CHANNELS; k++) begin
      @(posedge clock_in);
      violation_in <= 14'h3FFF << k;
    end
    @(posedge clock_in);
    violation_in <= CHAN_ZERO;
    wr(IDX_ACCESS_CTL, 32'h01);
    wr(IDX_COUNTER_CTL, 32'h08);
    rd_chk(IDX_COUNT_BYTE, 32'h0);
    wr(IDX_ACCESS_CTL, 32'h40);
    rd_chk(IDX_COUNT_BYTE, 32'h0);
    for (k = 1; k <= NUM_CHANNELS; k++) begin
      wr(IDX_ACCESS_CTL, 32'h40 | k);
      rd_chk(IDX_COUNT_BYTE, 32'(k));
    end
    wr(IDX_ACCESS_CTL, 32'h4F);
    rd_chk(IDX_COUNT_BYTE, 32'h0);
    // Violation activity on channel 0 shows one cycle later
    wr(IDX_ACCESS_CTL, 32'h41);
    @(posedge clock_in);
    violation_in <= 14'h0001;
    @(posedge clock_in);
    violation_in <= CHAN_ZERO;
    #1 check(32'(monitor_status_out[0]), 32'h1);
    // Clear of channel 0 only, held past the required time
    wr(IDX_COUNTER_CTL, 32'h01);
    repeat (110) @(posedge clock_in);
    wr(IDX_COUNTER_CTL, 32'h00);
    wr(IDX_COUNTER_CTL, 32'h02);
    rd_chk(IDX_COUNT_BYTE, 32'h0);
    wr(IDX_ACCESS_CTL, 32'h42);
    wr(IDX_COUNTER_CTL, 32'h00);
    wr(IDX_COUNTER_CTL, 32'h02);
    rd_chk(IDX_COUNT_BYTE, 32'h2);
    // High byte of a small held count is zero
    wr(IDX_ACCESS_CTL, 32'h43);
    wr(IDX_COUNTER_CTL, 32'h04);
    rd_chk(IDX_COUNT_BYTE, 32'h0);
    wr(IDX_COUNTER_CTL, 32'h00);
    // Drive channel 13 past full scale with its interrupt enabled
    wr(IDX_IRQ_MASK, 32'h2000);
    rd_chk(IDX_IRQ_MASK, 32'h2000);
    wr(IDX_ACCESS_CTL, 32'hCE);
    check(32'(irq_out), 32'h0);
    for (k = 0; k < 65526; k++) begin
      @(posedge clock_in);
      violation_in <= 14'h2000;
    end
    @(posedge clock_in);
    violation_in <= CHAN_ZERO;
    repeat (3) @(posedge clock_in);
    #1 check(32'(monitor_status_out), 32'h2000);
    check(32'(irq_out), 32'h1);
    rd_chk(IDX_IRQ_STATUS, 32'h2000);
    rd_chk(IDX_MONITOR, 32'h2000);
    wr(IDX_COUNTER_CTL, 32'h02);
    rd_chk(IDX_COUNT_BYTE, 32'hFF);
    wr(IDX_COUNTER_CTL, 32'h04);
    rd_chk(IDX_COUNT_BYTE, 32'hFF);
    // Write one to clear; saturation does not re-arm while held
    wr(IDX_IRQ_STATUS, 32'h2000);
    repeat (2) @(posedge clock_in);
    #1 check(32'(irq_out), 32'h0);
    rd_chk(IDX_IRQ_STATUS, 32'h0);
    // Clear of all channels
    wr(IDX_COUNTER_CTL, 32'h10);
    repeat (110) @(posedge clock_in);
    wr(IDX_COUNTER_CTL, 32'h00);
    wr(IDX_COUNTER_CTL, 32'h02);
    rd_chk(IDX_COUNT_BYTE, 32'h0);
    #1 check(32'(monitor_status_out), 32'h0);
    // Mid-run reset returns every register to its default
    wr(IDX_ACCESS_CTL, 32'hC5);
    @(posedge clock_in);
    resetn_in <= 1'b0;
    repeat (2) @(posedge clock_in);
    resetn_in <= 1'b1;
    rd_chk(IDX_ACCESS_CTL, 32'h0);
    rd_chk(IDX_IRQ_MASK, 32'h0);
    rd_chk(IDX_COUNTER_CTL, 32'h0);
    conclude();
  end
endmodule
`default_nettype wire
